//--- pbsi_pkg.sv
// Constants for the basic status and identifier register bank
package pbsi_pkg;
   localparam logic [4:0]  ADDR_STATUS     = 5'h01;
   localparam logic [4:0]  ADDR_ID_HIGH    = 5'h02;
   localparam int          BIT_T4          = 15;
   localparam int          BIT_TX_FD       = 14;
   localparam int          BIT_TX_HD       = 13;
   localparam int          BIT_10_FD       = 12;
   localparam int          BIT_10_HD       = 11;
   localparam int          BIT_AN_DONE     = 5;
   localparam int          BIT_RFAULT      = 4;
   localparam int          BIT_AN_ABLE     = 3;
   localparam int          BIT_LINK        = 2;
   localparam int          BIT_JABBER      = 1;
   localparam int          BIT_EXT_CAP     = 0;
   localparam logic        RST_TX_FD       = 1'b1;
   localparam logic        RST_TX_HD       = 1'b1;
   localparam logic        RST_10_FD       = 1'b1;
   localparam logic        RST_10_HD       = 1'b1;
   localparam logic        VAL_AN_ABLE     = 1'b1;
   localparam logic        VAL_EXT_CAP     = 1'b1;
   // Arbitrary neutral identifier value
   localparam logic [15:0] ID_HIGH_DEFAULT = 16'h0a5c;
   localparam logic [15:0] DATA_ZERO       = 16'h0000;
endpackage : pbsi_pkg

//--- pbsi_regs.sv
// Basic mode status and first identifier register bank
module pbsi_regs #(
   parameter logic [15:0] ID_HIGH = pbsi_pkg::ID_HIGH_DEFAULT
) (
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_rd_en,
   input  wire logic [4:0]  i_rd_addr,
   input  wire logic        i_mode_t4,
   input  wire logic        i_mode_fx,
   input  wire logic        i_mode_10bt,
   input  wire logic        i_an_complete,
   input  wire logic        i_remote_fault,
   input  wire logic        i_fx_far_end_fault,
   input  wire logic        i_link_pass,
   input  wire logic        i_jabber,
   output logic [15:0]      o_rd_data,
   output logic             o_rd_valid
);

   logic        rfault_ff;
   logic        nxt_rfault;
   logic        link_fail_ff;
   logic        nxt_link_fail;
   logic        link_prev_ff;
   logic        nxt_link_prev;
   logic        jabber_ff;
   logic        nxt_jabber;
   logic [15:0] rd_data_ff;
   logic [15:0] nxt_rd_data;
   logic        rd_valid_ff;
   logic        nxt_rd_valid;
   logic        fault_src;
   logic        status_rd;
   logic [15:0] status_word;

   // Source of the far-end fault depends on medium
   assign fault_src = i_mode_fx ? i_fx_far_end_fault
                                : i_remote_fault;
   assign status_rd = i_rd_en && (i_rd_addr == pbsi_pkg::ADDR_STATUS);

   // Status word assembly; reserved bits read zero
   always_comb begin
      status_word = pbsi_pkg::DATA_ZERO;
      status_word[pbsi_pkg::BIT_T4]      = i_mode_t4;
      status_word[pbsi_pkg::BIT_TX_FD]   = pbsi_pkg::RST_TX_FD;
      status_word[pbsi_pkg::BIT_TX_HD]   = pbsi_pkg::RST_TX_HD;
      status_word[pbsi_pkg::BIT_10_FD]   = pbsi_pkg::RST_10_FD;
      status_word[pbsi_pkg::BIT_10_HD]   = pbsi_pkg::RST_10_HD;
      status_word[pbsi_pkg::BIT_AN_DONE] = i_an_complete;
      status_word[pbsi_pkg::BIT_RFAULT]  = rfault_ff;
      status_word[pbsi_pkg::BIT_AN_ABLE] = pbsi_pkg::VAL_AN_ABLE;
      // Latched failure masks a live link until read
      status_word[pbsi_pkg::BIT_LINK]    = i_link_pass && !link_fail_ff;
      status_word[pbsi_pkg::BIT_JABBER]  = jabber_ff;
      status_word[pbsi_pkg::BIT_EXT_CAP] = pbsi_pkg::VAL_EXT_CAP;
   end

   // Event latches: a set in the read cycle always wins
   always_comb begin
      nxt_rfault    = rfault_ff;
      nxt_link_fail = link_fail_ff;
      nxt_link_prev = i_link_pass;
      nxt_jabber    = jabber_ff;
      // Clears use the same edge that captures the data
      if (status_rd) begin
         if (!fault_src) begin
            nxt_rfault = 1'b0;
         end
         nxt_link_fail = 1'b0;
         nxt_jabber    = 1'b0;
      end
      if (fault_src) begin
         nxt_rfault = 1'b1;
      end
      if (link_prev_ff && !i_link_pass) begin
         nxt_link_fail = 1'b1;
      end
      // Jabber is only meaningful in 10BT operation
      if (i_jabber && i_mode_10bt) begin
         nxt_jabber = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         rfault_ff    <= 1'b0;
         link_fail_ff <= 1'b0;
         link_prev_ff <= 1'b0;
         jabber_ff    <= 1'b0;
      end else begin
         rfault_ff    <= nxt_rfault;
         link_fail_ff <= nxt_link_fail;
         link_prev_ff <= nxt_link_prev;
         jabber_ff    <= nxt_jabber;
      end
   end

   // Read port; unmapped addresses return zero
   always_comb begin
      nxt_rd_valid = i_rd_en;
      nxt_rd_data  = rd_data_ff;
      if (i_rd_en) begin
         case (i_rd_addr)
            pbsi_pkg::ADDR_STATUS: begin
               nxt_rd_data = status_word;
            end
            pbsi_pkg::ADDR_ID_HIGH: begin
               nxt_rd_data = ID_HIGH;
            end
            default: begin
               nxt_rd_data = pbsi_pkg::DATA_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         rd_data_ff  <= pbsi_pkg::DATA_ZERO;
         rd_valid_ff <= 1'b0;
      end else begin
         rd_data_ff  <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
      end
   end

   assign o_rd_data  = rd_data_ff;
   assign o_rd_valid = rd_valid_ff;

endmodule : pbsi_regs

//--- pbsi_sva.sv
// Assertions for the status and identifier register bank
module pbsi_sva #(parameter logic [15:0] ID_HIGH = 16'h0000) (
   input wire logic i_clk, i_rstn, i_rd_en, i_mode_t4, i_mode_fx,
   input wire logic i_mode_10bt, i_an_complete, i_remote_fault,
   input wire logic i_fx_far_end_fault, i_link_pass, i_jabber, o_rd_valid,
   input wire logic [4:0] i_rd_addr,
   input wire logic [15:0] o_rd_data
);
   logic st_q, jb_q, rf_q, lp_q, lf_q;
   // Events seen under reset never count
   always_ff @(posedge i_clk) begin
      st_q <= i_rstn && i_rd_en && i_rd_addr == pbsi_pkg::ADDR_STATUS;
      jb_q <= i_rstn && i_jabber && i_mode_10bt;
      rf_q <= i_rstn && (i_mode_fx ? i_fx_far_end_fault : i_remote_fault);
      lp_q <= i_rstn && i_link_pass;
      // Failure since the last status read; a new drop beats the clear
      lf_q <= i_rstn && ((lp_q && !i_link_pass) || (lf_q && !(i_rd_en &&
         i_rd_addr == pbsi_pkg::ADDR_STATUS)));
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   a_valid_follows: assert property (i_rd_en |=> o_rd_valid)
      else $error("no answer");
   a_valid_pulse: assert property (!i_rd_en |=> !o_rd_valid)
      else $error("stray answer");
   a_fixed_bits: assert property (st_q |->
      o_rd_data[14:11] == 4'hf && o_rd_data[3] && o_rd_data[0])
      else $error("fixed bits");
   a_live_bits: assert property (st_q |->
      o_rd_data[15] == $past(i_mode_t4) &&
      o_rd_data[5] == $past(i_an_complete)) else $error("live bits");
   a_fault_latch: assert property (
      st_q && $past(rf_q) |-> o_rd_data[4]) else $error("fault lost");
   a_jabber_latch: assert property (
      st_q && $past(jb_q) |-> o_rd_data[1]) else $error("jabber lost");
   a_link_down: assert property (
      st_q && !$past(i_link_pass) |-> !o_rd_data[2]) else $error("link");
   a_link_latch: assert property (
      st_q && $past(lf_q) |-> !o_rd_data[2]) else $error("link latch");
   a_id_word: assert property (
      o_rd_valid && $past(i_rd_addr) == pbsi_pkg::ADDR_ID_HIGH |->
      o_rd_data == ID_HIGH) else $error("identifier");
endmodule : pbsi_sva
bind pbsi_regs pbsi_sva #(.ID_HIGH(ID_HIGH)) u_sva (.*);

//--- pbsi_host.sv
// Station manager model issuing single reads
module pbsi_host (
   input  wire logic        i_clk,
   input  wire logic [15:0] i_rd_data,
   input  wire logic        i_rd_valid,
   output logic             o_rd_en = 1'b0,
   output logic [4:0]       o_rd_addr = 5'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   // Reads only, so reserved bits are never written
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(negedge i_clk);
      o_rd_en = 1'b1;
      o_rd_addr = a;
      @(negedge i_clk);
      o_rd_en = 1'b0;
      o_rd_addr = ~a;
      // A late answer reads as unknown
      d = i_rd_valid ? i_rd_data : 16'hxxxx;
      // Reserved status bits disregarded
      if (a == pbsi_pkg::ADDR_STATUS) d = d & 16'hf83f;
   endtask : rd
endmodule : pbsi_host

//--- tb_top.sv
// Random bench for the status and identifier register bank
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk, i_rstn, i_rd_en, o_rd_valid, g, lnk, flt, jab;
   logic i_mode_t4, i_mode_fx, i_mode_10bt, i_an_complete, i_link_pass;
   logic i_remote_fault, i_fx_far_end_fault, i_jabber;
   logic [4:0] i_rd_addr, a;
   logic [15:0] o_rd_data, d;
   int err_total = 0;
   int checked = 0;
   pbsi_regs dut (.*);
   pbsi_host host (.i_clk(i_clk), .i_rd_data(o_rd_data),
      .i_rd_valid(o_rd_valid), .o_rd_en(i_rd_en), .o_rd_addr(i_rd_addr));
   task automatic chk(string n, logic [4:0] ad, logic [15:0] e);
      host.rd(ad, d);
      checked++;
      if (d !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, d);
      end
   endtask : chk
   task automatic st_chk(string n, logic f, logic l, logic j);
      chk(n, pbsi_pkg::ADDR_STATUS, {i_mode_t4, 4'hf,
         5'h00, i_an_complete, f, 1'b1, l, j, 1'b1});
   endtask : st_chk
   task automatic test_done;
      if (err_total == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   initial begin
      {i_rstn, i_mode_t4, i_mode_fx, i_mode_10bt, i_an_complete, i_link_pass,
         i_remote_fault, i_fx_far_end_fault, i_jabber} = 9'h000;
      void'($urandom(32'he4a8_7a26));
      repeat (12) @(negedge i_clk);
      i_rstn = 1'b1;
      repeat (300) begin
         {i_mode_t4, i_mode_fx, i_mode_10bt, i_an_complete, lnk, g,
            i_remote_fault, i_fx_far_end_fault, i_jabber} = 9'($urandom);
         i_link_pass = lnk;
         flt = i_mode_fx ? i_fx_far_end_fault : i_remote_fault;
         jab = i_jabber & i_mode_10bt;
         // One-cycle link drop must still be seen later
         @(negedge i_clk) i_link_pass = lnk & ~g;
         @(negedge i_clk) {i_remote_fault, i_fx_far_end_fault, i_jabber} = '0;
         i_link_pass = lnk;
         st_chk("status", flt, lnk & ~g, jab);
         st_chk("cleared", 1'b0, lnk, 1'b0);
         a = 5'($urandom);
         if (a == pbsi_pkg::ADDR_STATUS || g) a = pbsi_pkg::ADDR_ID_HIGH;
         chk("other", a, (a == pbsi_pkg::ADDR_ID_HIGH) ?
            pbsi_pkg::ID_HIGH_DEFAULT : 16'h0000);
      end
      test_done;
   end
endmodule : tb_top
